// file: spp_defs.vh
// Constants for the servo position parameter logic: register offsets,
// field positions, reset values, codes and limits.
// Assumes a plain register port with 32-bit data and byte offsets.
`ifndef SPP_DEFS_VH
`define SPP_DEFS_VH

// ************************************************************
// Register offsets
// ************************************************************
`define SPP_OFS_GEAR_NUM 8'h00
`define SPP_OFS_GEAR_DEN 8'h04
`define SPP_OFS_FEED_SEL 8'h08
`define SPP_OFS_GAIN_MODE 8'h0C
`define SPP_OFS_RESP_LVL 8'h10
`define SPP_OFS_FOLLOW_UP 8'h14
`define SPP_OFS_ACTIVE 8'h18
`define SPP_OFS_STATE 8'h1C
`define SPP_OFS_IRQ_STAT 8'h20
`define SPP_OFS_IRQ_MASK 8'h24
`define SPP_OFS_POSITION 8'h28

// ************************************************************
// Fields and reset values
// ************************************************************
`define SPP_GEAR_DEF 16'h0001
`define SPP_FEED_LSB 0
`define SPP_FEED_MSB 1
`define SPP_MPG_LSB 4
`define SPP_MPG_MSB 5
`define SPP_FEED_SEL_DEF 6'h00
`define SPP_GAIN_MODE_DEF 2'h1
`define SPP_RESP_LVL_DEF 6'h0C
`define SPP_RESP_LVL_MIN 6'h01
`define SPP_RESP_LVL_MAX 6'h20
`define SPP_ENC_RES_DEF 20'h40000

// Gear ratio limits: 1/10 < num/den < 2000
`define SPP_GEAR_LO_MUL 24'h00000A
`define SPP_GEAR_HI_MUL 27'h00007D0

// Command travel limit in feed units (999.999 at factor 1)
`define SPP_TRAVEL_MAX 32'sh000F423F

// Feed length factors and manual pulse factors
`define SPP_FACT_1 11'h001
`define SPP_FACT_10 11'h00A
`define SPP_FACT_100 11'h064
`define SPP_FACT_1000 11'h3E8

// Gain adjust mode codes
`define SPP_MODE_INTERP 2'h0
`define SPP_MODE_AUTO1 2'h1
`define SPP_MODE_AUTO2 2'h2
`define SPP_MODE_MANUAL 2'h3

// Auto-set mask bits: inertia, model gain, pos gain, speed gain, integral
`define SPP_AUTO_INTERP 5'h17
`define SPP_AUTO_ALL 5'h1F
`define SPP_AUTO_NO_INERTIA 5'h0F
`define SPP_AUTO_NONE 5'h00

// Interrupt status bits
`define SPP_IRQ_PARAM 0
`define SPP_IRQ_RANGE 1
`define SPP_IRQ_REJECT 2
`define SPP_IRQ_DONE 3
`define SPP_IRQ_W 4

`endif

// file: spp_position_param.v
// Power-up latched positioning configuration of a servo amplifier:
// electronic gear, feed and manual pulse factors, gain mode, follow-up.
// Assumes one 100 MHz clock; servo-on, forced stop, alarm reset, manual
// pulse and power-cycle come from pins; commands come from same-clock logic.
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`include "spp_defs.vh"

module spp_position_param (
  // Clock and reset
  input wire sys_clk_i,
  input wire rst_n_i,
  // Register port
  input wire [7:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o,
  // Pins (asynchronous)
  input wire power_cycle_i,
  input wire servo_on_request_i,
  input wire forced_stop_input_i,
  input wire alarm_reset_input_i,
  input wire mpg_pulse_i,
  // Alarm and home from the control loop (same clock)
  input wire ext_alarm_i,
  input wire home_set_i,
  // Position command (same clock)
  input wire cmd_valid_i,
  input wire cmd_abs_i,
  input wire signed [31:0] cmd_travel_i,
  output wire cmd_ready_o,
  // Scaled motor pulse output
  output reg pulse_valid_o,
  output reg signed [47:0] pulse_count_o,
  // Configuration and state to the motor loop
  output reg parameter_error_alarm_o,
  output reg [4:0] auto_set_o,
  output reg [5:0] tuning_response_level_o,
  output reg home_valid_o,
  output wire motion_ok_o,
  output wire irq_o
);

  // ************************************************************
  // Functions
  // ************************************************************

  // Feed length factor from code
  function [10:0] feed_factor;
    input [1:0] code;
    begin
      case (code)
        2'h0: feed_factor = `SPP_FACT_1;
        2'h1: feed_factor = `SPP_FACT_10;
        2'h2: feed_factor = `SPP_FACT_100;
        default: feed_factor = `SPP_FACT_1000;
      endcase
    end
  endfunction

  // Two-flop synchroniser stage helper is not needed; see sync block

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  reg [4:0] sync1_r;
  reg [4:0] sync2_r;
  reg [4:0] sync3_r;
  wire pwr_s = sync2_r[0];
  wire servo_s = sync2_r[1];
  wire estop_s = sync2_r[2];
  wire ares_rise = sync2_r[3] & ~sync3_r[3];
  wire mpg_rise = sync2_r[4] & ~sync3_r[4];
  wire pwr_rise = pwr_s & ~sync3_r[0];

  // Two flops per pin, third flop for edge detect
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
      sync3_r <= 5'h00;
    end else begin
      sync1_r <= {mpg_pulse_i, alarm_reset_input_i, forced_stop_input_i,
                  servo_on_request_i, power_cycle_i};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // ************************************************************
  // Staged settings (written by software any time)
  // ************************************************************
  reg [15:0] gear_numerator_r;
  reg [15:0] gear_denominator_r;
  reg [5:0] feed_function_select_r;
  reg [1:0] gain_adjust_mode_r;
  reg [5:0] tuning_response_level_r;
  reg follow_up_option_r;
  reg [`SPP_IRQ_W-1:0] irq_mask_r;
  wire wr_hit_num = reg_wr_i && (reg_addr_i == `SPP_OFS_GEAR_NUM);

  // Software writes to staged settings and mask
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      gear_numerator_r <= `SPP_GEAR_DEF;
      gear_denominator_r <= `SPP_GEAR_DEF;
      feed_function_select_r <= `SPP_FEED_SEL_DEF;
      gain_adjust_mode_r <= `SPP_GAIN_MODE_DEF;
      tuning_response_level_r <= `SPP_RESP_LVL_DEF;
      follow_up_option_r <= 1'b0;
      irq_mask_r <= {`SPP_IRQ_W{1'b0}};
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `SPP_OFS_GEAR_NUM: gear_numerator_r <= reg_wdata_i[15:0];
        `SPP_OFS_GEAR_DEN: gear_denominator_r <= reg_wdata_i[15:0];
        `SPP_OFS_FEED_SEL: feed_function_select_r <= reg_wdata_i[5:0];
        `SPP_OFS_GAIN_MODE: gain_adjust_mode_r <= reg_wdata_i[1:0];
        `SPP_OFS_RESP_LVL: tuning_response_level_r <= reg_wdata_i[5:0];
        `SPP_OFS_FOLLOW_UP: follow_up_option_r <= reg_wdata_i[0];
        `SPP_OFS_IRQ_MASK: irq_mask_r <= reg_wdata_i[`SPP_IRQ_W-1:0];
        default: irq_mask_r <= irq_mask_r;
      endcase
    end
  end

  // ************************************************************
  // Active settings, latched at power-up only
  // ************************************************************
  reg load_pend_r;
  reg [19:0] act_num_r;
  reg [15:0] act_den_r;
  reg [1:0] act_feed_r;
  reg [1:0] act_mpg_r;
  reg [1:0] act_mode_r;
  reg act_follow_r;
  wire [19:0] eff_num = (gear_numerator_r == 16'h0000) ? `SPP_ENC_RES_DEF :
                        {4'h0, gear_numerator_r};
  wire [26:0] num_x10 = eff_num * `SPP_GEAR_LO_MUL;
  wire [26:0] den_x2000 = gear_denominator_r * `SPP_GEAR_HI_MUL;
  // Strict bounds; zero denominator fails the upper bound
  wire gear_bad = (num_x10 <= {11'h000, gear_denominator_r}) ||
                  ({7'h00, eff_num} >= den_x2000);
  wire lvl_bad = (tuning_response_level_r < `SPP_RESP_LVL_MIN) ||
                 (tuning_response_level_r > `SPP_RESP_LVL_MAX);
  wire do_load = load_pend_r | pwr_rise;
  wire param_err_set = do_load & (gear_bad | lvl_bad);

  // Copy staged to active at reset release or power cycle
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      load_pend_r <= 1'b1;
      act_num_r <= {4'h0, `SPP_GEAR_DEF};
      act_den_r <= `SPP_GEAR_DEF;
      act_feed_r <= 2'h0;
      act_mpg_r <= 2'h0;
      act_mode_r <= `SPP_GAIN_MODE_DEF;
      tuning_response_level_o <= `SPP_RESP_LVL_DEF;
      act_follow_r <= 1'b0;
      parameter_error_alarm_o <= 1'b0;
    end else begin
      load_pend_r <= 1'b0;
      if (do_load) begin
        act_num_r <= eff_num;
        act_den_r <= gear_denominator_r;
        act_feed_r <= feed_function_select_r[`SPP_FEED_MSB:`SPP_FEED_LSB];
        act_mpg_r <= feed_function_select_r[`SPP_MPG_MSB:`SPP_MPG_LSB];
        act_mode_r <= gain_adjust_mode_r;
        tuning_response_level_o <= tuning_response_level_r;
        act_follow_r <= follow_up_option_r;
        parameter_error_alarm_o <= gear_bad | lvl_bad;
      end
    end
  end

  // Gain mode decode to auto-set mask
  always @* begin
    case (act_mode_r)
      `SPP_MODE_INTERP: auto_set_o = `SPP_AUTO_INTERP;
      `SPP_MODE_AUTO1: auto_set_o = `SPP_AUTO_ALL;
      `SPP_MODE_AUTO2: auto_set_o = `SPP_AUTO_NO_INERTIA;
      default: auto_set_o = `SPP_AUTO_NONE;
    endcase
  end

  // ************************************************************
  // Alarm, home and follow-up
  // ************************************************************
  reg alarm_r;
  wire stopped = ~servo_s | estop_s;
  assign motion_ok_o = ~stopped & ~alarm_r & ~parameter_error_alarm_o;

  // External alarm held until the reset pin
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      alarm_r <= 1'b0;
    end else if (ext_alarm_i) begin
      alarm_r <= 1'b1;
    end else if (ares_rise) begin
      alarm_r <= 1'b0;
    end
  end

  // Home kept through stop only with follow-up
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      home_valid_o <= 1'b0;
    end else if (home_set_i && motion_ok_o) begin
      home_valid_o <= 1'b1;
    end else if ((stopped | alarm_r) && !act_follow_r) begin
      home_valid_o <= 1'b0;
    end
  end

  // ************************************************************
  // Command scaling
  // ************************************************************
  reg signed [47:0] pos_r;
  reg signed [63:0] rem_r;
  reg mpg_pend_r;
  wire signed [11:0] feed_f = {1'b0, feed_factor(act_feed_r)};
  wire signed [11:0] mpg_f = {1'b0, feed_factor(act_mpg_r)};
  wire over_max = cmd_travel_i > `SPP_TRAVEL_MAX;
  wire under_min = cmd_abs_i ? (cmd_travel_i < -`SPP_TRAVEL_MAX) :
                   (cmd_travel_i < 32'sh00000000);
  wire range_bad = over_max | under_min;
  wire not_ready = ~motion_ok_o | (cmd_abs_i & ~home_valid_o);
  wire cmd_take = cmd_valid_i & ~range_bad & ~not_ready;
  wire mpg_take = mpg_pend_r & ~cmd_valid_i & motion_ok_o;
  assign cmd_ready_o = ~not_ready;
  wire signed [47:0] cmd_um = cmd_travel_i * feed_f;
  wire signed [47:0] delta = ~cmd_take ? {{36{mpg_f[11]}}, mpg_f} :
                             cmd_abs_i ? (cmd_um - pos_r) : cmd_um;
  wire signed [63:0] num_s = {44'h00000000000, act_num_r};
  wire signed [63:0] den_s = {48'h000000000000, act_den_r};
  wire signed [63:0] prod = delta * num_s + rem_r;
  wire signed [63:0] quot = prod / den_s;
  wire signed [63:0] quot_den = quot * den_s;

  // Pending manual pulse waits behind a command
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      mpg_pend_r <= 1'b0;
    end else if (mpg_rise) begin
      mpg_pend_r <= 1'b1;
    end else if (mpg_take || !motion_ok_o) begin
      mpg_pend_r <= 1'b0;
    end
  end

  // Scale, carry remainder, track commanded position
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pos_r <= 48'sh000000000000;
      rem_r <= 64'sh0000000000000000;
      pulse_valid_o <= 1'b0;
      pulse_count_o <= 48'sh000000000000;
    end else begin
      pulse_valid_o <= cmd_take | mpg_take;
      if (cmd_take || mpg_take) begin
        pulse_count_o <= quot[47:0];
        rem_r <= prod - quot_den;
        pos_r <= pos_r + delta;
      end else begin
        // Position forgotten with home; remainder dropped on a settings load (do_load) in a cycle with no pulse taken, whether or not the gear changed
        if (!home_valid_o) begin
          pos_r <= 48'sh000000000000;
        end
        if (do_load) begin
          rem_r <= 64'sh0000000000000000;
        end
      end
    end
  end

  // ************************************************************
  // Interrupt status
  // ************************************************************
  reg [`SPP_IRQ_W-1:0] irq_stat_r;
  wire [`SPP_IRQ_W-1:0] irq_set = {pulse_valid_o, cmd_valid_i & ~range_bad & not_ready,
                                   cmd_valid_i & range_bad, param_err_set};
  wire clr_hit = reg_wr_i && (reg_addr_i == `SPP_OFS_IRQ_STAT);
  wire [`SPP_IRQ_W-1:0] irq_clr = clr_hit ? reg_wdata_i[`SPP_IRQ_W-1:0] :
                                  {`SPP_IRQ_W{1'b0}};
  assign irq_o = |(irq_stat_r & irq_mask_r);

  // Sticky bits, set wins over write-one clear
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      irq_stat_r <= {`SPP_IRQ_W{1'b0}};
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
    end
  end

  // ************************************************************
  // Read port, data one cycle after strobe
  // ************************************************************
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `SPP_OFS_GEAR_NUM: reg_rdata_o <= {16'h0000, gear_numerator_r};
        `SPP_OFS_GEAR_DEN: reg_rdata_o <= {16'h0000, gear_denominator_r};
        `SPP_OFS_FEED_SEL: reg_rdata_o <= {26'h0000000, feed_function_select_r};
        `SPP_OFS_GAIN_MODE: reg_rdata_o <= {30'h00000000, gain_adjust_mode_r};
        `SPP_OFS_RESP_LVL: reg_rdata_o <= {26'h0000000, tuning_response_level_r};
        `SPP_OFS_FOLLOW_UP: reg_rdata_o <= {31'h00000000, follow_up_option_r};
        `SPP_OFS_ACTIVE: reg_rdata_o <= {act_num_r[11:0], act_follow_r, act_mode_r,
                                         act_mpg_r, act_feed_r, act_den_r[12:0]};
        `SPP_OFS_STATE: reg_rdata_o <= {26'h0000000, mpg_pend_r, alarm_r, stopped,
                                        motion_ok_o, home_valid_o,
                                        parameter_error_alarm_o};
        `SPP_OFS_IRQ_STAT: reg_rdata_o <= {28'h0000000, irq_stat_r};
        `SPP_OFS_IRQ_MASK: reg_rdata_o <= {28'h0000000, irq_mask_r};
        `SPP_OFS_POSITION: reg_rdata_o <= pos_r[31:0];
        default: reg_rdata_o <= 32'h00000000;
      endcase
    end else begin
      reg_rdata_o <= 32'h00000000;
    end
  end

endmodule // spp_position_param

// file: spp_position_param_properties.sv
// Checker for the servo position parameter logic, bound to its top.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
`include "spp_defs.vh"
module spp_prop_chk (
  // Clock and reset
  input wire sys_clk_i,
  input wire rst_n_i,
  // Watched ports
  input wire power_cycle_i,
  input wire cmd_valid_i,
  input wire cmd_abs_i,
  input wire signed [31:0] cmd_travel_i,
  input wire cmd_ready_o,
  input wire pulse_valid_o,
  input wire signed [47:0] pulse_count_o,
  input wire parameter_error_alarm_o,
  input wire [4:0] auto_set_o,
  input wire [5:0] tuning_response_level_o,
  input wire home_valid_o,
  input wire motion_ok_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ************************************************************
  // Command and configuration relations
  // ************************************************************
  a_pulse_after_cmd: assert property (cmd_valid_i && cmd_ready_o
    && cmd_travel_i <= `SPP_TRAVEL_MAX && cmd_travel_i >= (cmd_abs_i ? -`SPP_TRAVEL_MAX : 0)
    |=> pulse_valid_o) else $error("accepted command gave no pulse");
  a_refuse_unready: assert property (cmd_valid_i && !cmd_ready_o |=> !pulse_valid_o)
    else $error("pulse while not ready");
  a_refuse_range: assert property (cmd_valid_i && cmd_travel_i > `SPP_TRAVEL_MAX
    |=> !pulse_valid_o) else $error("out of range command moved");
  a_ready_rule: assert property (cmd_ready_o == (motion_ok_o && (!cmd_abs_i || home_valid_o)))
    else $error("ready wrong");
  a_err_blocks: assert property (parameter_error_alarm_o |-> !motion_ok_o)
    else $error("motion with parameter error");
  a_auto_legal: assert property (auto_set_o inside {5'h17, 5'h1F, 5'h0F, 5'h00})
    else $error("bad auto set mask");
  a_level_range: assert property (tuning_response_level_o >= 6'h01
    && tuning_response_level_o <= 6'h20) else $error("level out of range");
  a_cfg_stable: assert property ((!power_cycle_i) [*5] |-> $stable(auto_set_o)
    && $stable(tuning_response_level_o)) else $error("settings changed without power cycle");
  a_count_hold: assert property (!pulse_valid_o |-> $stable(pulse_count_o))
    else $error("count changed without pulse");
endmodule // spp_prop_chk
bind spp_position_param spp_prop_chk u_chk (.*);

// file: spp_host_model.sv
// Host controller model issuing position commands one cycle after a request.
// Assumes requests come from the bench at the rising clock edge.
`timescale 1ns/100ps
module spp_host_model (
  // Clock
  input wire sys_clk_i,
  // Requests
  input wire go_i,
  input wire abs_i,
  input wire signed [31:0] travel_i,
  // Command port
  output reg cmd_valid_o,
  output reg cmd_abs_o,
  output reg signed [31:0] cmd_travel_o
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_abs_o = 1'b0;
    cmd_travel_o = 32'h0;
  end
  // Drive a command, scramble travel while idle
  always @(posedge sys_clk_i) begin
    cmd_valid_o <= go_i;
    cmd_abs_o <= abs_i;
    cmd_travel_o <= go_i ? travel_i : ~cmd_travel_o;
  end
endmodule // spp_host_model

// file: spp_position_param_bench.sv
// Self-checking bench for the servo position parameter logic.
// Assumes the host model drives the command port.
`timescale 1ns/100ps
`include "spp_defs.vh"
module spp_position_param_bench;
  reg sys_clk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, go = 1'b0, h_abs = 1'b0;
  reg power_cycle_i = 1'b0, servo_on_request_i = 1'b0, forced_stop_input_i = 1'b0;
  reg alarm_reset_input_i = 1'b0, mpg_pulse_i = 1'b0, ext_alarm_i = 1'b0, home_set_i = 1'b0;
  reg [7:0] reg_addr_i = 8'h00;
  reg [31:0] reg_wdata_i = 32'h0;
  reg signed [31:0] h_t = 32'h0;
  wire cmd_valid_i, cmd_abs_i, cmd_ready_o, pulse_valid_o, parameter_error_alarm_o;
  wire home_valid_o, motion_ok_o, irq_o;
  wire signed [31:0] cmd_travel_i;
  wire [31:0] reg_rdata_o;
  wire signed [47:0] pulse_count_o;
  wire [4:0] auto_set_o;
  wire [5:0] tuning_response_level_o;
  integer err_count = 0, n_tests = 0, cycles = 0, i;
  reg [4:0] tbl [0:3];
  reg [47:0] fac [0:3];
  reg [31:0] gn [0:3], gd [0:3];
  always #5 sys_clk_i = ~sys_clk_i;
  spp_host_model host (.sys_clk_i(sys_clk_i), .go_i(go), .abs_i(h_abs), .travel_i(h_t),
    .cmd_valid_o(cmd_valid_i), .cmd_abs_o(cmd_abs_i), .cmd_travel_o(cmd_travel_i));
  spp_position_param dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .power_cycle_i(power_cycle_i),
    .servo_on_request_i(servo_on_request_i), .forced_stop_input_i(forced_stop_input_i),
    .alarm_reset_input_i(alarm_reset_input_i), .mpg_pulse_i(mpg_pulse_i),
    .ext_alarm_i(ext_alarm_i), .home_set_i(home_set_i), .cmd_valid_i(cmd_valid_i),
    .cmd_abs_i(cmd_abs_i), .cmd_travel_i(cmd_travel_i), .cmd_ready_o(cmd_ready_o),
    .pulse_valid_o(pulse_valid_o), .pulse_count_o(pulse_count_o),
    .parameter_error_alarm_o(parameter_error_alarm_o), .auto_set_o(auto_set_o),
    .tuning_response_level_o(tuning_response_level_o), .home_valid_o(home_valid_o),
    .motion_ok_o(motion_ok_o), .irq_o(irq_o));
  // ************************************************************
  // Access and compare tasks
  // ************************************************************
  task chk(input [47:0] got, input [47:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("BAD %0t got %0h expected %0h", $time, got, exp);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b0;
      #1 chk({16'h0, reg_rdata_o}, {16'h0, e});
    end
  endtask
  task pcyc;
    begin
      @(posedge sys_clk_i);
      power_cycle_i <= 1'b1;
      cyc(4);
      power_cycle_i <= 1'b0;
      cyc(4);
      #1;
    end
  endtask
  task cfg(input [31:0] n, input [31:0] d, input [31:0] sel, input [31:0] fol);
    begin
      wr(`SPP_OFS_GEAR_NUM, n);
      wr(`SPP_OFS_GEAR_DEN, d);
      wr(`SPP_OFS_FEED_SEL, sel);
      wr(`SPP_OFS_FOLLOW_UP, fol);
      pcyc;
    end
  endtask
  task cmd(input ab, input signed [31:0] t, input v, input [47:0] c);
    begin
      @(posedge sys_clk_i);
      go <= 1'b1;
      h_abs <= ab;
      h_t <= t;
      @(posedge sys_clk_i);
      go <= 1'b0;
      @(posedge sys_clk_i);
      #1 chk({47'h0, pulse_valid_o}, {47'h0, v});
      if (v) chk(pulse_count_o, c);
    end
  endtask
  task note(input [8*8-1:0] s);
    $display("test %0s done at %0t", s, $time);
  endtask
  task final_report;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // Cut a hang short
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count = err_count + 1;
      final_report;
    end
  end
  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    tbl[0] = 5'h17; tbl[1] = 5'h1F; tbl[2] = 5'h0F; tbl[3] = 5'h00;
    fac[0] = 48'h1; fac[1] = 48'hA; fac[2] = 48'h64; fac[3] = 48'h3E8;
    gn[0] = 32'h1; gn[1] = 32'h2; gn[2] = 32'h4E20; gn[3] = 32'h4E1F;
    gd[0] = 32'hA; gd[1] = 32'hA; gd[2] = 32'hA; gd[3] = 32'hA;
    cyc(5);
    rst_n_i <= 1'b1;
    cyc(3);
    rd(`SPP_OFS_GEAR_NUM, 32'h1);
    rd(`SPP_OFS_GEAR_DEN, 32'h1);
    rd(`SPP_OFS_GAIN_MODE, 32'h1);
    rd(`SPP_OFS_RESP_LVL, 32'hC);
    rd(8'h40, 32'h0);
    chk(auto_set_o, 5'h1F);
    servo_on_request_i <= 1'b1;
    cyc(4);
    cmd(1'b0, 32'sh5, 1'b1, 48'h5);
    wr(`SPP_OFS_RESP_LVL, 32'h14);
    cyc(6);
    chk(tuning_response_level_o, 6'h0C);
    pcyc;
    chk(tuning_response_level_o, 6'h14);
    for (i = 0; i < 4; i = i + 1) begin
      wr(`SPP_OFS_GAIN_MODE, i);
      pcyc;
      chk(auto_set_o, tbl[i]);
    end
    note("config");
    for (i = 0; i < 4; i = i + 1) begin
      cfg(32'h1, 32'h1, i, 32'h0);
      cmd(1'b0, 32'sh3, 1'b1, 48'h3 * fac[i]);
    end
    cfg(32'h0, 32'hC8, 32'h0, 32'h0);
    cmd(1'b0, 32'sh1, 1'b1, 48'h51E);
    cmd(1'b0, 32'sh1, 1'b1, 48'h51F);
    // Host keeps every gear value inside 16 bits
    for (i = 0; i < 4; i = i + 1) begin
      cfg(gn[i], gd[i], 32'h0, 32'h0);
      chk(parameter_error_alarm_o, (i % 2 == 0));
    end
    note("gear");
    cmd(1'b0, -32'sh1, 1'b0, 48'h0);
    cmd(1'b0, 32'sh000F4240, 1'b0, 48'h0);
    cmd(1'b1, 32'sh5, 1'b0, 48'h0);
    rd(`SPP_OFS_IRQ_STAT, 32'hF);
    wr(`SPP_OFS_IRQ_STAT, 32'hF);
    rd(`SPP_OFS_IRQ_STAT, 32'h0);
    wr(`SPP_OFS_IRQ_MASK, 32'h8);
    cmd(1'b0, 32'sh1, 1'b1, 48'h7CF);
    cyc(1);
    #1 chk(irq_o, 1'b1);
    wr(`SPP_OFS_IRQ_MASK, 32'h0);
    #1 chk(irq_o, 1'b0);
    wr(`SPP_OFS_IRQ_MASK, 32'h8);
    wr(`SPP_OFS_IRQ_STAT, 32'h8);
    #1 chk(irq_o, 1'b0);
    note("irq");
    for (i = 0; i < 3; i = i + 1) begin
      cfg(32'h1, 32'h1, i << 4, 32'h0);
      mpg_pulse_i <= 1'b1;
      cyc(3);
      mpg_pulse_i <= 1'b0;
      cyc(6);
      chk(pulse_count_o, fac[i]);
    end
    cfg(32'h1, 32'h1, 32'h0, 32'h1);
    home_set_i <= 1'b1;
    cyc(1);
    home_set_i <= 1'b0;
    forced_stop_input_i <= 1'b1;
    cyc(4);
    chk({motion_ok_o, home_valid_o}, 2'h1);
    forced_stop_input_i <= 1'b0;
    cyc(4);
    cmd(1'b1, 32'sh5, 1'b1, 48'h5);
    ext_alarm_i <= 1'b1;
    cyc(1);
    ext_alarm_i <= 1'b0;
    cyc(2);
    chk(motion_ok_o, 1'b0);
    alarm_reset_input_i <= 1'b1;
    cyc(3);
    alarm_reset_input_i <= 1'b0;
    cyc(4);
    chk({motion_ok_o, home_valid_o}, 2'h3);
    cfg(32'h1, 32'h1, 32'h0, 32'h0);
    home_set_i <= 1'b1;
    cyc(1);
    home_set_i <= 1'b0;
    servo_on_request_i <= 1'b0;
    cyc(4);
    chk(home_valid_o, 1'b0);
    note("follow");
    final_report;
  end
endmodule // spp_position_param_bench
